// file: pbm_bus_match.sv
/*
	Port-B bus matching, byte swapping, mailbox bypass and parity for a dual-queue buffer.
	Assumes queue arrays, flags and mailboxes live outside and share ref_clk.
*/
// Operation
// - First queue unloads whole long words only
// - Narrow reads present pieces from auxiliary register
// - New size read unloads fresh long word
// - Unused output lanes hold their last value
// - Second queue stores whole long words only
// - Last narrow piece stores assembled long word
// - New size write restarts assembly
// - Both size bits high access mailboxes
// - Mailbox access leaves sizing state untouched
// - Registered size and endian steer each edge
// - Four byte orders, whole bytes, mailbox unswapped
// - Swap order sampled once per long word
// - Reads swap then split; writes assemble then swap
// - Port B flags only valid lanes
// - Four nine-bit bytes, top bit parity
// - Parity sense follows odd/even select
// - Port A mailbox generate read forces flag high
// - Port B mailbox generate read forces flag high
// - Generate select substitutes computed parity bits
// - Writes store all nine bits unchanged
// - Parity inserted only when loading new long word
// - Mailbox parity uses shared trees, contents kept
// - Size and endian selects captured each edge, used next edge
// - Big endian uses upper lanes, little lower
module pbm_bus_match (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic parity_odd_sel,
	input wire logic chip_sel_a_n,
	input wire logic port_a_enable,
	input wire logic write_not_read_a,
	input wire logic mailbox_sel_a,
	input wire logic parity_gen_a,
	input wire logic [35:0] a_data_in,
	input wire logic [35:0] b2a_mail_data,
	output logic [35:0] a_mail_out,
	input wire logic a_fifo_load,
	input wire logic [35:0] b2a_ram_rd_data,
	output logic [35:0] a_fifo_out,
	output logic parity_err_a_n,
	input wire logic chip_sel_b_n,
	input wire logic port_b_enable,
	input wire logic write_not_read_b,
	input wire logic size_sel_lo,
	input wire logic size_sel_hi,
	input wire logic endian_sel,
	input wire logic swap_sel_lo,
	input wire logic swap_sel_hi,
	input wire logic parity_gen_b,
	input wire logic [35:0] b_data_in,
	input wire logic [35:0] a2b_mail_data,
	output logic [35:0] b_mail_out,
	output logic a2b_mail_read,
	output logic b2a_mail_write,
	input wire logic [35:0] a2b_ram_rd_data,
	input wire logic a2b_ram_ready,
	output logic a2b_ram_pop,
	output logic [35:0] b_fifo_out,
	input wire logic b2a_ram_ready,
	output logic b2a_ram_push,
	output logic [35:0] b2a_ram_wr_data,
	output logic parity_err_b_n
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	pbm_pkg::pbm_state_t st_q;
	pbm_pkg::pbm_state_t st_d;
	logic [2:0] sel_in;
	logic [1:0] swap_now;
	logic [1:0] cur_size;
	logic cur_big;
	logic sel_b;
	logic mail_b;
	logic rd_fifo;
	logic wr_fifo;
	logic fresh;
	logic a_mail_gen;
	logic b_mail_gen;
	logic [35:0] tree_a_in;
	logic [35:0] tree_b_in;
	logic [3:0] gen_a;
	logic [3:0] gen_b;
	logic [3:0] fail_a;
	logic [3:0] fail_b;
	logic [35:0] rd_word;
	logic [1:0] rd_idx;
	logic rd_out;
	logic [1:0] wr_idx;
	logic [1:0] wr_swap;
	logic [35:0] wr_full;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign sel_in = {size_sel_hi, size_sel_lo, endian_sel};
	assign swap_now = {swap_sel_hi, swap_sel_lo};
	assign cur_size = st_q.sel_q[2:1];
	assign cur_big = st_q.sel_q[0];
	assign sel_b = ~chip_sel_b_n & port_b_enable;
	assign mail_b = (cur_size == pbm_pkg::SZ_MAIL);
	assign rd_fifo = sel_b & ~write_not_read_b & ~mail_b;
	assign wr_fifo = sel_b & write_not_read_b & ~mail_b;
	assign fresh = ~st_q.rd_live_q | (st_q.rd_mode_q != st_q.sel_q);
	assign a2b_mail_read = sel_b & ~write_not_read_b & mail_b;
	assign b2a_mail_write = sel_b & write_not_read_b & mail_b;

	// ----------------------------------------
	// Shared parity trees
	// ----------------------------------------
	// trees shared with mailboxes
	assign a_mail_gen = ~chip_sel_a_n & port_a_enable & ~write_not_read_a & mailbox_sel_a
		& parity_gen_a;
	assign b_mail_gen = a2b_mail_read & parity_gen_b;
	assign tree_a_in = a_mail_gen ? b2a_mail_data : a_data_in;
	assign tree_b_in = b_mail_gen ? a2b_mail_data : b_data_in;

	pbm_parity4 u_tree_a (
		.data(tree_a_in),
		.odd_sel(parity_odd_sel),
		.gen_bits(gen_a),
		.fail_bits(fail_a)
	);

	pbm_parity4 u_tree_b (
		.data(tree_b_in),
		.odd_sel(parity_odd_sel),
		.gen_bits(gen_b),
		.fail_bits(fail_b)
	);

	assign a_mail_out = a_mail_gen ? pbm_pkg::put_parity(b2a_mail_data, gen_a) : b2a_mail_data;
	assign b_mail_out = b_mail_gen ? pbm_pkg::put_parity(a2b_mail_data, gen_b) : a2b_mail_data;
	assign parity_err_a_n = a_mail_gen | ~|fail_a;
	assign parity_err_b_n = b_mail_gen | ~|(fail_b & pbm_pkg::lane_mask(cur_size, cur_big));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_d = st_q;
		st_d.push_q = 1'b0;
		a2b_ram_pop = 1'b0;
		rd_word = st_q.aux_q;
		rd_idx = st_q.rd_idx_q;
		rd_out = 1'b0;
		wr_idx = st_q.wr_idx_q;
		wr_swap = st_q.wr_swap_q;
		wr_full = st_q.asm_q;
		st_d.sel_q = sel_in;
		if (a_fifo_load)
			st_d.afout_q = pbm_pkg::add_parity(b2a_ram_rd_data, parity_gen_a, parity_odd_sel);
		if (rd_fifo)
		begin
			if (fresh)
			begin
				rd_word = pbm_pkg::add_parity(pbm_pkg::swap_bytes(a2b_ram_rd_data, swap_now),
					parity_gen_b, parity_odd_sel);
				rd_idx = 2'h0;
				if (a2b_ram_ready)
				begin
					a2b_ram_pop = 1'b1;
					st_d.aux_q = rd_word;
					st_d.rd_mode_q = st_q.sel_q;
					rd_out = 1'b1;
				end
			end
			else
			begin
				rd_out = 1'b1;
			end
			if (rd_out)
			begin
				unique case (cur_size)
					pbm_pkg::SZ_WORD:
						if (cur_big)
							st_d.fout_q[35:18] = rd_word[18*pbm_pkg::word_pos(rd_idx) +: 18];
						else
							st_d.fout_q[17:0] = rd_word[18*pbm_pkg::word_pos(rd_idx) +: 18];
					pbm_pkg::SZ_BYTE:
						if (cur_big)
							st_d.fout_q[35:27] = rd_word[9*pbm_pkg::byte_pos(rd_idx) +: 9];
						else
							st_d.fout_q[8:0] = rd_word[9*pbm_pkg::byte_pos(rd_idx) +: 9];
					default:
						st_d.fout_q = rd_word;
				endcase
				st_d.rd_idx_q = rd_idx + 2'h1;
				st_d.rd_live_q = (rd_idx != pbm_pkg::last_idx(cur_size));
			end
		end
		if (wr_fifo)
		begin
			if (st_q.wr_mode_q != st_q.sel_q)
				wr_idx = 2'h0;
			if (wr_idx == 2'h0)
				wr_swap = swap_now;
			unique case (cur_size)
				pbm_pkg::SZ_WORD:
					wr_full[18*pbm_pkg::word_pos(wr_idx) +: 18] =
						cur_big ? b_data_in[35:18] : b_data_in[17:0];
				pbm_pkg::SZ_BYTE:
					wr_full[9*pbm_pkg::byte_pos(wr_idx) +: 9] =
						cur_big ? b_data_in[35:27] : b_data_in[8:0];
				default:
					wr_full = b_data_in;
			endcase
			if (wr_idx == pbm_pkg::last_idx(cur_size))
			begin
				if (b2a_ram_ready)
				begin
					st_d.push_q = 1'b1;
					st_d.wdata_q = pbm_pkg::swap_bytes(wr_full, wr_swap);
					st_d.wr_idx_q = 2'h0;
					st_d.wr_mode_q = st_q.sel_q;
				end
			end
			else
			begin
				st_d.asm_q = wr_full;
				st_d.wr_idx_q = wr_idx + 2'h1;
				st_d.wr_swap_q = wr_swap;
				st_d.wr_mode_q = st_q.sel_q;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			st_q <= pbm_pkg::ST_RESET;
		else
			st_q <= st_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign a_fifo_out = st_q.afout_q;
	assign b_fifo_out = st_q.fout_q;
	assign b2a_ram_push = st_q.push_q;
	assign b2a_ram_wr_data = st_q.wdata_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	long_read_load_a: assert property (
		(rd_fifo && fresh && a2b_ram_ready && cur_size == pbm_pkg::SZ_LONG)
		|=> (b_fifo_out == $past(rd_word)))
		else $error("Long read did not load the whole word.");
	piece_no_pop_a: assert property (
		(rd_fifo && !fresh) |-> !a2b_ram_pop)
		else $error("Narrow piece read unloaded the queue.");
	new_size_pop_a: assert property (
		(rd_fifo && st_q.rd_live_q && st_q.rd_mode_q != st_q.sel_q && a2b_ram_ready)
		|-> a2b_ram_pop)
		else $error("New size read kept stale pieces.");
	lane_static_a: assert property (
		(rd_fifo && cur_size == pbm_pkg::SZ_WORD) |=> ($past(cur_big)
		? b_fifo_out[17:0] == $past(b_fifo_out[17:0])
		: b_fifo_out[35:18] == $past(b_fifo_out[35:18])))
		else $error("Unused word lanes changed.");
	long_write_push_a: assert property (
		(wr_fifo && cur_size == pbm_pkg::SZ_LONG && b2a_ram_ready)
		|=> (b2a_ram_push && b2a_ram_wr_data ==
		pbm_pkg::swap_bytes($past(b_data_in), $past(swap_now))))
		else $error("Long write not stored at once.");
	fourth_byte_a: assert property (
		(wr_fifo && cur_size == pbm_pkg::SZ_BYTE && st_q.wr_mode_q == st_q.sel_q
		&& st_q.wr_idx_q == 2'h3 && b2a_ram_ready) |=> b2a_ram_push)
		else $error("Fourth byte did not store the long word.");
	asm_restart_a: assert property (
		(wr_fifo && st_q.wr_mode_q != st_q.sel_q && cur_size != pbm_pkg::SZ_LONG)
		|=> (st_q.wr_idx_q == 2'h1 && !b2a_ram_push))
		else $error("New size write did not restart assembly.");
	mail_bypass_a: assert property (
		(sel_b && mail_b) |-> (!a2b_ram_pop ##1 !b2a_ram_push))
		else $error("Mailbox access touched a queue.");
	mail_keep_a: assert property (
		(sel_b && mail_b) |=> (st_q.rd_idx_q == $past(st_q.rd_idx_q)
		&& st_q.wr_idx_q == $past(st_q.wr_idx_q)))
		else $error("Mailbox access disturbed sizing.");
	sel_capture_a: assert property (
		##1 (st_q.sel_q == $past(sel_in)))
		else $error("Size selects not captured.");
	parity_err_a_n_force_a: assert property (
		a_mail_gen |-> parity_err_a_n)
		else $error("Port A flag not held high.");
	parity_err_b_n_force_a: assert property (
		b_mail_gen |-> parity_err_b_n)
		else $error("Port B flag not held high.");

endmodule : pbm_bus_match

// file: pbm_pkg.sv
/*
	Shared constants, state layout and byte helpers for the port-B bus-matching data path.
	Assumes one clock domain and 36-bit long words made of four nine-bit bytes.
*/
package pbm_pkg;

	// ----------------------------------------
	// Size codes, taken as {size_sel_hi, size_sel_lo}
	// ----------------------------------------
	localparam logic [1:0] SZ_LONG = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_BYTE = 2'h2;
	localparam logic [1:0] SZ_MAIL = 2'h3;

	// constant piece order
	// Pieces of a long word go most-significant first when set.
	localparam logic MSB_FIRST = 1'h1;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] sel_q;
		logic [2:0] rd_mode_q;
		logic [1:0] rd_idx_q;
		logic rd_live_q;
		logic [35:0] aux_q;
		logic [35:0] fout_q;
		logic [2:0] wr_mode_q;
		logic [1:0] wr_idx_q;
		logic [1:0] wr_swap_q;
		logic [35:0] asm_q;
		logic [35:0] wdata_q;
		logic push_q;
		logic [35:0] afout_q;
	} pbm_state_t;

	localparam pbm_state_t ST_RESET = '0;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [1:0] last_idx(input logic [1:0] sz);
		return (sz == SZ_WORD) ? 2'h1 : ((sz == SZ_BYTE) ? 2'h3 : 2'h0);
	endfunction : last_idx

	function automatic logic [3:0] lane_mask(input logic [1:0] sz, input logic big);
		if (sz == SZ_WORD)
			return big ? 4'hc : 4'h3;
		if (sz == SZ_BYTE)
			return big ? 4'h8 : 4'h1;
		return 4'hf;
	endfunction : lane_mask

	function automatic logic [35:0] swap_bytes(input logic [35:0] w, input logic [1:0] m);
		unique case (m)
			2'h0: return w;
			2'h1: return {w[8:0], w[17:9], w[26:18], w[35:27]};
			2'h2: return {w[17:9], w[8:0], w[35:27], w[26:18]};
			2'h3: return {w[26:18], w[35:27], w[8:0], w[17:9]};
		endcase
	endfunction : swap_bytes

	function automatic logic [3:0] par_bits(input logic [35:0] w, input logic odd);
		logic [3:0] r;
		for (int i = 0; i < 4; i++)
			r[i] = odd ? ~^w[9*i +: 8] : ^w[9*i +: 8];
		return r;
	endfunction : par_bits

	function automatic logic [35:0] put_parity(input logic [35:0] w, input logic [3:0] p);
		return {p[3], w[34:27], p[2], w[25:18], p[1], w[16:9], p[0], w[7:0]};
	endfunction : put_parity

	function automatic logic [35:0] add_parity(input logic [35:0] w, input logic gen,
		input logic odd);
		return gen ? put_parity(w, par_bits(w, odd)) : w;
	endfunction : add_parity

	function automatic logic [1:0] byte_pos(input logic [1:0] idx);
		return MSB_FIRST ? 2'h3 - idx : idx;
	endfunction : byte_pos

	function automatic logic word_pos(input logic [1:0] idx);
		return MSB_FIRST ? ~idx[0] : idx[0];
	endfunction : word_pos

endpackage : pbm_pkg

// file: pbm_parity4.sv
/*
	Four byte-wise parity trees: check bits for a 36-bit bus and generated parity bits.
	Assumes the caller muxes either bus input or mailbox data onto the trees.
*/
module pbm_parity4 (
	input wire logic [35:0] data,
	input wire logic odd_sel,
	output logic [3:0] gen_bits,
	output logic [3:0] fail_bits
);

	// ----------------------------------------
	// Trees
	// ----------------------------------------
	assign gen_bits = pbm_pkg::par_bits(data, odd_sel);

	for (genvar i = 0; i < 4; i++)
	begin : g_tree
		assign fail_bits[i] = odd_sel ? ~^data[9*i +: 9] : ^data[9*i +: 9];
	end

endmodule : pbm_parity4

// file: pbm_ram_model.sv
/*
	Behavioural far side of the port-B data path: the two queue RAMs.
	Assumes one clock shared with the design and stall controls from the bench.
*/
module pbm_ram_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic stall_a2b,
	input wire logic stall_b2a,
	input wire logic a2b_ram_pop,
	output logic [35:0] a2b_ram_rd_data,
	output logic a2b_ram_ready,
	input wire logic b2a_ram_push,
	output logic b2a_ram_ready,
	output logic [7:0] pop_count,
	output logic [7:0] push_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [35:0] head;
	// ----------------------------------------
	// Queue ends
	// ----------------------------------------
	// whole long words.
	assign head = {9'h0a1 + 9'(pop_count), 9'h152 + 9'(pop_count), 9'h0c3 + 9'(pop_count),
		9'h1e4 + 9'(pop_count)};
	assign a2b_ram_ready = !stall_a2b;
	// An empty queue shows no stale word on its read port.
	assign a2b_ram_rd_data = a2b_ram_ready ? head : ~head;
	assign b2a_ram_ready = !stall_b2a;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pop_count <= 8'h00;
			push_count <= 8'h00;
		end
		else
		begin
			pop_count <= pop_count + 8'(a2b_ram_pop && a2b_ram_ready);
			push_count <= push_count + 8'(b2a_ram_push && b2a_ram_ready);
		end
	end
endmodule : pbm_ram_model

// file: pbm_bus_match_bench.sv
/*
	Self-checking bench for the port-B bus-matching data path.
	Assumes the queue RAM model and a 50 MHz clock with synchronous reset.
*/
module pbm_bus_match_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, sys_rst, parity_odd_sel, chip_sel_a_n, port_a_enable, write_not_read_a;
	logic mailbox_sel_a, parity_gen_a, a_fifo_load, chip_sel_b_n, port_b_enable, write_not_read_b;
	logic size_sel_lo, size_sel_hi, endian_sel, swap_sel_lo, swap_sel_hi, parity_gen_b;
	logic stall_a2b, stall_b2a, a2b_mail_read, b2a_mail_write, a2b_ram_ready, a2b_ram_pop;
	logic b2a_ram_ready, b2a_ram_push, parity_err_a_n, parity_err_b_n;
	logic [35:0] a_data_in, b2a_mail_data, a_mail_out, b2a_ram_rd_data, a_fifo_out, b_data_in;
	logic [35:0] a2b_mail_data, b_mail_out, a2b_ram_rd_data, b_fifo_out, b2a_ram_wr_data, exp, s;
	logic [7:0] pop_count, push_count, n;
	int errors, n_compared, cyc;

	pbm_bus_match u_pbm_bus_match (.ref_clk, .sys_rst, .parity_odd_sel, .chip_sel_a_n,
		.port_a_enable, .write_not_read_a, .mailbox_sel_a, .parity_gen_a, .a_data_in,
		.b2a_mail_data, .a_mail_out, .a_fifo_load, .b2a_ram_rd_data, .a_fifo_out,
		.parity_err_a_n, .chip_sel_b_n, .port_b_enable, .write_not_read_b, .size_sel_lo,
		.size_sel_hi, .endian_sel, .swap_sel_lo, .swap_sel_hi, .parity_gen_b, .b_data_in,
		.a2b_mail_data, .b_mail_out, .a2b_mail_read, .b2a_mail_write, .a2b_ram_rd_data,
		.a2b_ram_ready, .a2b_ram_pop, .b_fifo_out, .b2a_ram_ready, .b2a_ram_push,
		.b2a_ram_wr_data, .parity_err_b_n);
	pbm_ram_model u_pbm_ram_model (.ref_clk, .sys_rst, .stall_a2b, .stall_b2a, .a2b_ram_pop,
		.a2b_ram_rd_data, .a2b_ram_ready, .b2a_ram_push, .b2a_ram_ready, .pop_count,
		.push_count);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [35:0] h(input logic [7:0] c);
		return {9'h0a1 + 9'(c), 9'h152 + 9'(c), 9'h0c3 + 9'(c), 9'h1e4 + 9'(c)};
	endfunction : h
	function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] m);
		logic [8:0] a, b, c, d;
		{a, b, c, d} = w;
		case (m)
			2'h1: return {d, c, b, a};
			2'h2: return {c, d, a, b};
			2'h3: return {b, a, d, c};
			default: return w;
		endcase
	endfunction : swp
	function automatic logic [35:0] gen(input logic [35:0] w, input logic odd);
		for (int k = 0; k < 4; k++)
			w[9*k+8] = odd ^ (^w[9*k +: 8]);
		return w;
	endfunction : gen
	function automatic logic [35:0] put(input logic [35:0] o, input logic [35:0] v,
		input logic [1:0] sz, input logic big, input int i);
		if (sz == pbm_pkg::SZ_WORD && big)
			o[35:18] = (i != 0) ? v[17:0] : v[35:18];
		else if (sz == pbm_pkg::SZ_WORD)
			o[17:0] = (i != 0) ? v[17:0] : v[35:18];
		else if (sz == pbm_pkg::SZ_BYTE && big)
			o[35:27] = v[35-9*i -: 9];
		else if (sz == pbm_pkg::SZ_BYTE)
			o[8:0] = v[35-9*i -: 9];
		else
			o = v;
		return o;
	endfunction : put
	task automatic step;
		@(posedge ref_clk);
		#2;
	endtask : step
	task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic set_size(input logic [1:0] sz, input logic big);
		{size_sel_hi, size_sel_lo} = sz;
		endian_sel = big;
		port_b_enable = 1'h0;
		step();
	endtask : set_size
	task automatic rd(input logic fresh);
		write_not_read_b = 1'h0;
		port_b_enable = 1'h1;
		#1;
		chk("a2b_ram_pop", 36'(fresh), 36'(a2b_ram_pop));
		step();
		n = n + 8'(fresh);
	endtask : rd
	task automatic rdx(input logic fresh, input logic [1:0] sz, input logic big, input int i);
		rd(fresh);
		exp = put(exp, s, sz, big, i);
		chk("b_fifo_out", exp, b_fifo_out);
	endtask : rdx
	task automatic wr(input logic [35:0] d, input logic last, input logic [35:0] e);
		write_not_read_b = 1'h1;
		port_b_enable = 1'h1;
		b_data_in = d;
		step();
		chk("b2a_ram_push", 36'(last), 36'(b2a_ram_push));
		if (last)
			chk("b2a_ram_wr_data", e, b2a_ram_wr_data);
	endtask : wr

	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		{parity_odd_sel, port_a_enable, write_not_read_a, mailbox_sel_a, parity_gen_a} = '0;
		{a_fifo_load, port_b_enable, write_not_read_b, size_sel_lo, size_sel_hi} = '0;
		{endian_sel, swap_sel_lo, swap_sel_hi, parity_gen_b, stall_a2b, stall_b2a} = '0;
		{a_data_in, b2a_ram_rd_data, b_data_in, exp, s, n} = '0;
		{chip_sel_a_n, chip_sel_b_n, sys_rst} = 3'h7;
		a2b_mail_data = 36'h9_8765_4321;
		b2a_mail_data = 36'h1_2345_6789;
		step();
		step();
		sys_rst = 1'h0;
		chip_sel_b_n = 1'h0;
		chk("b_fifo_out", 36'h0, b_fifo_out);
		for (int m = 0; m < 4; m++)
		begin
			{swap_sel_hi, swap_sel_lo} = 2'(m);
			s = swp(h(n), 2'(m));
			rdx(1'h1, pbm_pkg::SZ_LONG, 1'h0, 0);
		end
		stall_a2b = 1'h1;
		rd(1'h0);
		chk("b_fifo_out", exp, b_fifo_out);
		stall_a2b = 1'h0;
		set_size(pbm_pkg::SZ_BYTE, 1'h1);
		{swap_sel_hi, swap_sel_lo} = 2'h1;
		s = swp(h(n), 2'h1);
		rdx(1'h1, pbm_pkg::SZ_BYTE, 1'h1, 0);
		{swap_sel_hi, swap_sel_lo} = 2'h2;
		for (int i = 1; i < 4; i++)
			rdx(1'h0, pbm_pkg::SZ_BYTE, 1'h1, i);
		chk("pop_count", 36'(n), 36'(pop_count));
		set_size(pbm_pkg::SZ_WORD, 1'h0);
		{swap_sel_hi, swap_sel_lo} = 2'h0;
		s = h(n);
		rdx(1'h1, pbm_pkg::SZ_WORD, 1'h0, 0);
		set_size(pbm_pkg::SZ_MAIL, 1'h0);
		{swap_sel_hi, swap_sel_lo} = 2'h1;
		{parity_gen_b, parity_odd_sel, port_b_enable} = 3'h7;
		#1;
		chk("a2b_mail_read", 36'h1, 36'(a2b_mail_read));
		chk("b_mail_out", gen(a2b_mail_data, 1'h1), b_mail_out);
		chk("parity_err_b_n", 36'h1, 36'(parity_err_b_n));
		chk("a2b_ram_pop", 36'h0, 36'(a2b_ram_pop));
		step();
		parity_gen_b = 1'h0;
		{swap_sel_hi, swap_sel_lo} = 2'h0;
		set_size(pbm_pkg::SZ_WORD, 1'h0);
		rdx(1'h0, pbm_pkg::SZ_WORD, 1'h0, 1);
		s = h(n);
		rdx(1'h1, pbm_pkg::SZ_WORD, 1'h0, 0);
		set_size(pbm_pkg::SZ_LONG, 1'h0);
		parity_gen_b = 1'h1;
		s = gen(h(n), 1'h1);
		rdx(1'h1, pbm_pkg::SZ_LONG, 1'h0, 0);
		chk("pop_count", 36'(n), 36'(pop_count));
		for (int m = 0; m < 4; m++)
		begin
			{swap_sel_hi, swap_sel_lo} = 2'(m);
			wr(h(8'(40 + m)), 1'h1, swp(h(8'(40 + m)), 2'(m)));
		end
		set_size(pbm_pkg::SZ_WORD, 1'h1);
		{swap_sel_hi, swap_sel_lo} = 2'h2;
		wr({18'h2_1a3b, ~18'h2_1a3b}, 1'h0, 36'h0);
		{swap_sel_hi, swap_sel_lo} = 2'h0;
		wr({18'h0_5c7e, ~18'h0_5c7e}, 1'h1, swp({18'h2_1a3b, 18'h0_5c7e}, 2'h2));
		set_size(pbm_pkg::SZ_BYTE, 1'h0);
		wr({27'h0, 9'h155}, 1'h0, 36'h0);
		wr({27'h0, 9'h0aa}, 1'h0, 36'h0);
		set_size(pbm_pkg::SZ_WORD, 1'h0);
		wr({~18'h1_2222, 18'h1_2222}, 1'h0, 36'h0);
		wr({~18'h3_0001, 18'h3_0001}, 1'h1, {18'h1_2222, 18'h3_0001});
		set_size(pbm_pkg::SZ_BYTE, 1'h1);
		{swap_sel_hi, swap_sel_lo} = 2'h1;
		wr({9'h1a1, 27'h0}, 1'h0, 36'h0);
		{swap_sel_hi, swap_sel_lo} = 2'h3;
		wr({9'h0b2, 27'h0}, 1'h0, 36'h0);
		wr({9'h1c3, 27'h0}, 1'h0, 36'h0);
		wr({9'h0d4, 27'h0}, 1'h1, {9'h0d4, 9'h1c3, 9'h0b2, 9'h1a1});
		set_size(pbm_pkg::SZ_MAIL, 1'h0);
		{write_not_read_b, port_b_enable} = 2'h3;
		#1;
		chk("b2a_mail_write", 36'h1, 36'(b2a_mail_write));
		step();
		chk("b2a_ram_push", 36'h0, 36'(b2a_ram_push));
		chk("push_count", 36'h7, 36'(push_count));
		set_size(pbm_pkg::SZ_BYTE, 1'h1);
		b_data_in = {9'h001, 9'h001, 9'h001, 9'h000};
		#1;
		chk("parity_err_b_n", 36'h1, 36'(parity_err_b_n));
		b_data_in = {9'h000, 9'h001, 9'h001, 9'h001};
		chip_sel_a_n = 1'h0;
		a_data_in = {4{9'h001}};
		#1;
		chk("parity_err_b_n", 36'h0, 36'(parity_err_b_n));
		chk("parity_err_a_n", 36'h1, 36'(parity_err_a_n));
		a_data_in[26:18] = 9'h003;
		#1;
		chk("parity_err_a_n", 36'h0, 36'(parity_err_a_n));
		parity_odd_sel = 1'h0;
		a_data_in = {4{9'h003}};
		#1;
		chk("parity_err_a_n", 36'h1, 36'(parity_err_a_n));
		{port_a_enable, mailbox_sel_a, parity_gen_a} = 3'h7;
		a_data_in = {4{9'h001}};
		#1;
		chk("parity_err_a_n", 36'h1, 36'(parity_err_a_n));
		chk("a_mail_out", gen(b2a_mail_data, 1'h0), a_mail_out);
		step();
		port_a_enable = 1'h0;
		b2a_ram_rd_data = h(8'd60);
		a_fifo_load = 1'h1;
		step();
		a_fifo_load = 1'h0;
		chk("a_fifo_out", gen(h(8'd60), 1'h0), a_fifo_out);
		{parity_gen_a, parity_odd_sel} = 2'h1;
		step();
		chk("a_fifo_out", gen(h(8'd60), 1'h0), a_fifo_out);
		tally_and_finish();
	end
endmodule : pbm_bus_match_bench
